// File: fcs_pkg.sv
package fcs_pkg;

  // ********************************
  // Widths
  // ********************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PHASE_NS      = 50;
  localparam int PHASE_CYC     = (PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ********************************
  // Register map, byte offsets
  // ********************************
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // Status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_BYPASS  = 3;
  localparam int ST_SUSP    = 4;
  localparam int ST_OP_IDLE = 5;

  // Status bits on the flash data bus
  localparam int POLL_BIT         = 7;
  localparam int TOGGLE_BIT_ONE   = 6;
  localparam int TIMEOUT_FAIL_BIT = 5;

  // ********************************
  // Command words and addresses
  // ********************************
  localparam logic [10:0] ADR_UNLK1  = 11'h555;
  localparam logic [10:0] ADR_UNLK2  = 11'h2aa;
  localparam logic [10:0] ADR_QUERY  = 11'h055;
  localparam logic [7:0]  CMD_UNLK1  = 8'haa;
  localparam logic [7:0]  CMD_UNLK2  = 8'h55;
  localparam logic [7:0]  CMD_RESET  = 8'hf0;
  localparam logic [7:0]  CMD_IDENT  = 8'h90;
  localparam logic [7:0]  CMD_PROG   = 8'ha0;
  localparam logic [7:0]  CMD_BYPASS = 8'h20;
  localparam logic [7:0]  CMD_BYP_X2 = 8'h00;
  localparam logic [7:0]  CMD_ERASE  = 8'h80;
  localparam logic [7:0]  CMD_SECTOR = 8'h30;
  localparam logic [7:0]  CMD_SUSP   = 8'hb0;
  localparam logic [7:0]  CMD_RESUME = 8'h30;
  localparam logic [7:0]  CMD_QUERY  = 8'h98;
  localparam logic [7:0]  CMD_UNPROT = 8'h77;

  // ********************************
  // Operations
  // ********************************
  typedef enum logic [3:0] {
    OP_READ     = 4'h0,
    OP_RESET    = 4'h1,
    OP_PROGRAM  = 4'h2,
    OP_ERASE    = 4'h3,
    OP_BYPASS   = 4'h4,
    OP_BYP_EXIT = 4'h5,
    OP_ID       = 4'h6,
    OP_SUSPEND  = 4'h7,
    OP_RESUME   = 4'h8,
    OP_QUERY    = 4'h9,
    OP_UNPROT   = 4'ha
  } fcs_op_type;

endpackage

// File: fcs_seq_table.sv
`timescale 1ns/1ps
module fcs_seq_table
  import fcs_pkg::*;
(
  input  wire fcs_op_type         op,
  input  wire logic               bypass,
  input  wire logic [2:0]         step,
  input  wire logic [ADDR_W-1:0]  uaddr,
  input  wire logic [DATA_W-1:0]  udata,
  output logic      [ADDR_W-1:0]  cyc_addr,
  output logic      [DATA_W-1:0]  cyc_data,
  output logic                    cyc_read,
  output logic                    cyc_last
);

  // ********************************
  // Unlock addresses carry the bank bits
  // ********************************
  wire [ADDR_W-1:0] a1 = {uaddr[ADDR_W-1:11], ADR_UNLK1};
  wire [ADDR_W-1:0] a2 = {uaddr[ADDR_W-1:11], ADR_UNLK2};

  always_comb
  begin
    cyc_addr = a1;
    cyc_data = {8'h00, CMD_RESET};
    cyc_read = 1'b0;
    cyc_last = 1'b0;
    if (step == 3'd0)
    begin
      cyc_data = {8'h00, CMD_UNLK1};
    end
    else if (step == 3'd1)
    begin
      cyc_addr = a2;
      cyc_data = {8'h00, CMD_UNLK2};
    end
    unique case (op)
      OP_READ:
      begin
        cyc_addr = uaddr;
        cyc_read = 1'b1;
        cyc_last = 1'b1;
      end
      OP_RESET, OP_BYP_EXIT:
      begin
        if (bypass)
        begin
          cyc_data = (step == 3'd0) ? {8'h00, CMD_IDENT} : {8'h00, CMD_BYP_X2};
          cyc_last = (step == 3'd1);
        end
        else
        begin
          cyc_data = {8'h00, CMD_RESET};
          cyc_last = 1'b1;
        end
      end
      OP_PROGRAM:
      begin
        if (bypass)
        begin
          cyc_data = {8'h00, CMD_PROG};
          if (step == 3'd1)
          begin
            cyc_addr = uaddr;
            cyc_data = udata;
            cyc_last = 1'b1;
          end
        end
        else if (step == 3'd2)
        begin
          cyc_data = {8'h00, CMD_PROG};
        end
        else if (step == 3'd3)
        begin
          cyc_addr = uaddr;
          cyc_data = udata;
          cyc_last = 1'b1;
        end
      end
      OP_ERASE:
      begin
        if (step == 3'd2)
        begin
          cyc_data = {8'h00, CMD_ERASE};
        end
        else if (step == 3'd3)
        begin
          cyc_data = {8'h00, CMD_UNLK1};
        end
        else if (step == 3'd4)
        begin
          cyc_addr = a2;
          cyc_data = {8'h00, CMD_UNLK2};
        end
        else if (step == 3'd5)
        begin
          cyc_addr = uaddr;
          cyc_data = {8'h00, CMD_SECTOR};
          cyc_last = 1'b1;
        end
      end
      OP_BYPASS, OP_UNPROT:
      begin
        if (step == 3'd2)
        begin
          cyc_data = {8'h00, (op == OP_BYPASS) ? CMD_BYPASS : CMD_UNPROT};
          cyc_last = 1'b1;
        end
      end
      OP_ID:
      begin
        if (step == 3'd2)
        begin
          cyc_data = {8'h00, CMD_IDENT};
        end
        else if (step == 3'd3)
        begin
          cyc_addr = uaddr;
          cyc_read = 1'b1;
        end
        else if (step == 3'd4)
        begin
          cyc_data = {8'h00, CMD_RESET};
          cyc_last = 1'b1;
        end
      end
      OP_SUSPEND:
      begin
        cyc_addr = uaddr;
        cyc_data = {8'h00, CMD_SUSP};
        cyc_last = 1'b1;
      end
      OP_RESUME:
      begin
        cyc_data = {8'h00, CMD_RESUME};
        cyc_last = 1'b1;
      end
      OP_QUERY:
      begin
        cyc_addr = {uaddr[ADDR_W-1:11], ADR_QUERY};
        cyc_data = {8'h00, CMD_QUERY};
        cyc_last = 1'b1;
      end
      default:
      begin
        cyc_data = {8'h00, CMD_RESET};
        cyc_last = 1'b1;
      end
    endcase
  end

endmodule

// File: fcs_bus_engine.sv
`timescale 1ns/1ps
module fcs_bus_engine
  import fcs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               req,
  input  wire logic               req_read,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [DATA_W-1:0]  req_data,
  output logic                    done,
  output logic      [DATA_W-1:0]  rd_data_ff,
  output logic      [ADDR_W-1:0]  fl_addr_ff,
  output logic                    fl_ce_n,
  output logic                    fl_we_n,
  output logic                    fl_oe_n,
  input  wire logic [DATA_W-1:0]  dq_in,
  output logic      [DATA_W-1:0]  dq_out_ff,
  output logic                    dq_oe_n
);

  typedef enum logic [2:0] {
    E_IDLE   = 3'b000,
    E_SETUP  = 3'b001,
    E_STROBE = 3'b010,
    E_HOLD   = 3'b011,
    E_DONE   = 3'b100
  } fcs_eng_type;

  fcs_eng_type state_ff;
  fcs_eng_type nxt_state;
  logic [1:0]  cnt_ff;
  logic        read_ff;
  wire         tick = (cnt_ff == 2'(PHASE_CYC - 1));
  wire         active = (state_ff == E_SETUP) || (state_ff == E_STROBE) || (state_ff == E_HOLD);

  // ********************************
  // Pin decode
  // ********************************
  assign fl_ce_n = !active;
  assign fl_we_n = !((state_ff == E_STROBE) && !read_ff);
  assign fl_oe_n = !((state_ff == E_STROBE) && read_ff);
  assign dq_oe_n = !(active && !read_ff);
  assign done    = (state_ff == E_DONE);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      E_IDLE:   if (req) nxt_state = E_SETUP;
      E_SETUP:  if (tick) nxt_state = E_STROBE;
      E_STROBE: if (tick) nxt_state = E_HOLD;
      E_HOLD:   if (tick) nxt_state = E_DONE;
      E_DONE:   nxt_state = E_IDLE;
      default:  nxt_state = E_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff   <= E_IDLE;
      cnt_ff     <= 2'h0;
      read_ff    <= 1'b0;
      fl_addr_ff <= '0;
      dq_out_ff  <= '0;
      rd_data_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= (!active || tick) ? 2'h0 : cnt_ff + 2'h1;
      if (state_ff == E_IDLE && req)
      begin
        read_ff    <= req_read;
        fl_addr_ff <= req_addr;
        dq_out_ff  <= req_data;
      end
      if (state_ff == E_STROBE && tick && read_ff)
      begin
        rd_data_ff <= dq_in;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  a_addr_before_we: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(fl_we_n) |-> !fl_ce_n && $stable(fl_addr_ff))
    else $error("address moved at write strobe fall");
  a_data_at_we_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(fl_we_n) |-> !fl_ce_n && !dq_oe_n && $stable(dq_out_ff))
    else $error("write data not held at strobe rise");

endmodule

// File: fcs_flash_host.sv
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - All command cycles write, except two reads
// - Reset leaves identification mode or timeout fail
// - Identification read carries the bank address
// - Bypass program only after bypass entry
// - Bypass left only by bypass reset
// - Polling bit may lead; reread for data
module fcs_flash_host
  import fcs_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  output logic      [ADDR_W-1:0]  fl_addr,
  output logic                    fl_ce_n,
  output logic                    fl_we_n,
  output logic                    fl_oe_n,
  input  wire logic [DATA_W-1:0]  dq_in,
  output logic      [DATA_W-1:0]  dq_out,
  output logic                    dq_oe_n,
  input  wire logic               op_idle_pin
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SEQ   = 3'b001,
    H_POLL1 = 3'b010,
    H_POLL2 = 3'b011,
    H_FINAL = 3'b100,
    H_RST   = 3'b101
  } fcs_host_type;

  fcs_host_type      state_ff;
  fcs_host_type      nxt_state;
  fcs_op_type        op_ff;
  logic [2:0]        step_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              done_ff;
  logic              fail_ff;
  logic              bypass_ff;
  logic              susp_ff;
  logic              tog_ff;
  logic              rechk_ff;

  logic [ADDR_W-1:0] tbl_addr;
  logic [DATA_W-1:0] tbl_data;
  logic              tbl_read;
  logic              tbl_last;
  logic              eng_done;
  logic [DATA_W-1:0] eng_rdata;

  // ********************************
  // Register decode
  // ********************************
  wire busy       = (state_ff != H_IDLE);
  wire sel_cmd    = (avs_address == REG_CMD);
  wire sel_addr   = (avs_address == REG_ADDR);
  wire sel_wdata  = (avs_address == REG_WDATA);
  wire sel_rdata  = (avs_address == REG_RDATA);
  wire sel_status = (avs_address == REG_STATUS);
  wire cmd_start  = avs_write && sel_cmd && !busy;
  wire st_clr_w   = avs_write && sel_status;

  assign avs_waitrequest = avs_write && sel_cmd && busy;

  wire [31:0] status_word = {26'h0, op_idle_pin, susp_ff, bypass_ff,
                             fail_ff, done_ff, busy};

  assign avs_readdata = !avs_read  ? 32'h0             :
                        sel_addr   ? {12'h0, addr_ff}  :
                        sel_wdata  ? {16'h0, wdata_ff} :
                        sel_rdata  ? {16'h0, rdata_ff} :
                        sel_status ? status_word       :
                        sel_cmd    ? {28'h0, op_ff}    : 32'h0;

  // ********************************
  // Request to the bus engine
  // ********************************
  wire is_poll   = (state_ff == H_POLL1) || (state_ff == H_POLL2) || (state_ff == H_FINAL);
  wire req       = (state_ff != H_IDLE);
  wire req_read  = (state_ff == H_SEQ) ? tbl_read : is_poll;
  wire [ADDR_W-1:0] req_addr = (state_ff == H_SEQ) ? tbl_addr : addr_ff;
  wire [DATA_W-1:0] req_data = (state_ff == H_RST) ? {8'h00, CMD_RESET} : tbl_data;
  wire waits_status = (op_ff == OP_PROGRAM) || (op_ff == OP_ERASE);
  wire seq_end      = (state_ff == H_SEQ) && eng_done && tbl_last;
  wire tog_now      = eng_rdata[TOGGLE_BIT_ONE];
  wire toggling     = (tog_now != tog_ff);
  wire fail_now     = eng_rdata[TIMEOUT_FAIL_BIT];

  fcs_seq_table u_table (
    .op       (op_ff),
    .bypass   (bypass_ff),
    .step     (step_ff),
    .uaddr    (addr_ff),
    .udata    (wdata_ff),
    .cyc_addr (tbl_addr),
    .cyc_data (tbl_data),
    .cyc_read (tbl_read),
    .cyc_last (tbl_last)
  );

  fcs_bus_engine u_engine (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .req        (req),
    .req_read   (req_read),
    .req_addr   (req_addr),
    .req_data   (req_data),
    .done       (eng_done),
    .rd_data_ff (eng_rdata),
    .fl_addr_ff (fl_addr),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n),
    .dq_in      (dq_in),
    .dq_out_ff  (dq_out),
    .dq_oe_n    (dq_oe_n)
  );

  // ********************************
  // Sequencer
  // ********************************
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      H_IDLE:
        if (cmd_start) nxt_state = H_SEQ;
      H_SEQ:
        if (seq_end) nxt_state = waits_status ? H_POLL1 : H_IDLE;
      H_POLL1:
        if (eng_done) nxt_state = H_POLL2;
      H_POLL2:
        if (eng_done)
        begin
          if (!toggling) nxt_state = H_FINAL;
          else if (rechk_ff) nxt_state = H_RST;
          else nxt_state = H_POLL1;
        end
      H_FINAL:
        if (eng_done) nxt_state = H_IDLE;
      H_RST:
        if (eng_done) nxt_state = H_IDLE;
      default:
        nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= H_IDLE;
      step_ff  <= 3'h0;
      op_ff    <= OP_READ;
      addr_ff  <= '0;
      wdata_ff <= '0;
      tog_ff   <= 1'b0;
      rechk_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (cmd_start)
      begin
        op_ff   <= fcs_op_type'(avs_writedata[3:0]);
        step_ff <= 3'h0;
      end
      else if (state_ff == H_SEQ && eng_done)
      begin
        step_ff <= step_ff + 3'h1;
      end
      if (avs_write && sel_addr && !busy)
      begin
        addr_ff <= avs_writedata[ADDR_W-1:0];
      end
      if (avs_write && sel_wdata && !busy)
      begin
        wdata_ff <= avs_writedata[DATA_W-1:0];
      end
      if (state_ff == H_POLL1 && eng_done)
      begin
        tog_ff <= tog_now;
      end
      if (seq_end)
      begin
        rechk_ff <= 1'b0;
      end
      else if (state_ff == H_POLL2 && eng_done && toggling && fail_now)
      begin
        rechk_ff <= 1'b1;
      end
    end
  end

  // ********************************
  // Results and mode flags
  // ********************************
  wire done_set = eng_done && ((state_ff == H_FINAL) || (seq_end && !waits_status));
  wire fail_set = eng_done && (state_ff == H_RST);
  wire rd_take  = eng_done && (((state_ff == H_SEQ) && tbl_read) || (state_ff == H_FINAL));
  wire byp_exit = seq_end && (op_ff == OP_RESET || op_ff == OP_BYP_EXIT) && bypass_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_ff   <= 1'b0;
      fail_ff   <= 1'b0;
      bypass_ff <= 1'b0;
      susp_ff   <= 1'b0;
      rdata_ff  <= '0;
    end
    else
    begin
      done_ff <= done_set || (done_ff && !(st_clr_w && avs_writedata[ST_DONE]));
      fail_ff <= fail_set || (fail_ff && !(st_clr_w && avs_writedata[ST_FAIL]));
      if (rd_take)
      begin
        rdata_ff <= eng_rdata;
      end
      if (seq_end && op_ff == OP_BYPASS)
      begin
        bypass_ff <= 1'b1;
      end
      else if (byp_exit)
      begin
        bypass_ff <= 1'b0;
      end
      if (seq_end && op_ff == OP_SUSPEND)
      begin
        susp_ff <= 1'b1;
      end
      else if (seq_end && op_ff == OP_RESUME)
      begin
        susp_ff <= 1'b0;
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_reads_only_two: assert property (
    (state_ff == H_SEQ) && req_read |-> (op_ff == OP_READ) || ((op_ff == OP_ID) && (step_ff == 3'd3)))
    else $error("command cycle issued as read");
  a_id_then_reset: assert property (
    (state_ff == H_SEQ) && (op_ff == OP_ID) && eng_done && tbl_read
    |=> req && !req_read && (req_data[7:0] == CMD_RESET))
    else $error("identification not followed by reset");
  a_fail_resets: assert property (
    (state_ff == H_POLL2) && eng_done && toggling && rechk_ff
    |=> (state_ff == H_RST) && !req_read && (req_data[7:0] == CMD_RESET))
    else $error("timeout fail not followed by reset");
  a_id_bank_addr: assert property (
    (state_ff == H_SEQ) && (op_ff == OP_ID) && tbl_read |-> req_addr[19:12] == addr_ff[19:12])
    else $error("identification read lacks bank address");
  a_bypass_prog: assert property (
    (state_ff == H_SEQ) && (op_ff == OP_PROGRAM) && (step_ff == 3'd0)
    |-> bypass_ff == (req_data[7:0] == CMD_PROG))
    else $error("bypass program without bypass mode");
  a_bypass_exit: assert property (
    $fell(bypass_ff) |-> $past(state_ff) == H_SEQ && $past(req_data[7:0]) == CMD_BYP_X2)
    else $error("bypass left without bypass reset");
  a_final_reread: assert property (
    (state_ff == H_POLL2) && eng_done && !toggling
    |=> (state_ff == H_FINAL) && req_read && !done_ff[*2])
    else $error("no reread after status settled");

  c_program_done: cover property ((state_ff == H_FINAL) && eng_done && (op_ff == OP_PROGRAM));
  c_fail_reset:   cover property ((state_ff == H_RST) && eng_done);
  c_id_read:      cover property ((op_ff == OP_ID) && seq_end);

endmodule

// File: fcs_flash_model.sv
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [15:0] ID_CODE = 16'h1357, // Arbitrary value
  parameter int          BUSY_NS = 2000
)
(
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_we_n,
  input  wire logic              fl_oe_n,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe_n,
  input  wire logic              stuck,
  output logic      [DATA_W-1:0] dq_in,
  output logic                   op_idle_pin
);
  // ****************
  // Device model
  // ****************
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] rd;
  logic [10:0]       la = '0;
  logic [7:0]        pa = '0;
  logic [1:0]        ucnt = '0;
  logic [7:0]        lcmd = '0;
  logic              busy = 0, tgl = 0, ident = 0, byp = 0, bx = 0, armed = 0, er = 0, ers = 0;

  task automatic wr(input logic [15:0] d);
    if (busy)
      busy = (d[7:0] != CMD_RESET);
    else if (armed)
    begin
      mem[la[7:0]] = d;
      pa = la[7:0];
      {armed, er, busy} = 3'b001;
    end
    else if (byp && d[7:0] == CMD_PROG)
      armed = 1;
    else if (byp)
    begin
      byp = !(bx && d[7:0] == CMD_BYP_X2);
      bx = (d[7:0] == CMD_IDENT);
    end
    else if (ucnt == 2 && ers && d[7:0] == CMD_SECTOR)
    begin
      foreach (mem[i])
        mem[i] = 16'hffff;
      {ers, ucnt, er, busy} = 5'b00011;
    end
    else if (ucnt == 2 && la == ADR_UNLK1)
    begin
      armed = (d[7:0] == CMD_PROG);
      byp = (d[7:0] == CMD_BYPASS);
      ident = (d[7:0] == CMD_IDENT);
      ers = (d[7:0] == CMD_ERASE);
      ucnt = 0;
    end
    else if (d[7:0] == CMD_UNLK2 && la == ADR_UNLK2 && ucnt == 1)
      ucnt = 2;
    else if (d[7:0] == CMD_UNLK1 && la == ADR_UNLK1)
      ucnt = 1;
    else if (d[7:0] == CMD_RESET)
      {ident, ucnt} = 3'h0;
  endtask

  always @(negedge fl_we_n)
    if (!fl_ce_n)
      la = fl_addr[10:0];
  always @(posedge fl_we_n)
    if (!fl_ce_n)
    begin
      lcmd = dq_out[7:0];
      wr(dq_oe_n ? ~dq_out : dq_out);
    end
  always @(posedge busy)
  begin
    #BUSY_NS;
    busy = busy && stuck;
  end
  always @(posedge fl_oe_n)
    if (!fl_ce_n)
    begin
      last = rd;
      tgl = tgl ^ busy;
    end

  assign rd = busy ? {8'h00, !er && !mem[pa][7], tgl, stuck, 5'h00}
            : ident ? ID_CODE : mem[fl_addr[7:0]];
  assign dq_in = (fl_ce_n || fl_oe_n) ? ~last : rd;
  assign op_idle_pin = !busy;
endmodule

// File: fcs_flash_host_tb.sv
`timescale 1ns/1ps
module fcs_flash_host_tb
  import fcs_pkg::*;
;
  logic              core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, stuck = 0;
  logic [4:0]        avs_address = '0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata, q, st;
  logic              avs_waitrequest, fl_ce_n, fl_we_n, fl_oe_n, dq_oe_n, op_idle_pin, sb;
  logic [ADDR_W-1:0] fl_addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  int                err_count = 0, n_tests = 0, waits;

  fcs_flash_host DUT (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .op_idle_pin(op_idle_pin));
  fcs_flash_model FLASH (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .stuck(stuck),
    .dq_in(dq_in), .op_idle_pin(op_idle_pin));

  initial
    forever #12.5 core_clk = ~core_clk;

  // ****************
  // Shared tasks
  // ****************
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    waits = 0;
    do
    begin
      @(posedge core_clk);
      waits++;
    end
    while (avs_waitrequest !== 1'b0 && waits < 4000);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (waits >= 4000)
    begin
      err_count++;
      report_and_stop;
    end
    @(posedge core_clk);
  endtask

  task automatic fin;
    sb = 0;
    for (int n = 0; n < 400 && !(q[ST_DONE] | q[ST_FAIL]); n++)
    begin
      bus(0, REG_STATUS, 32'h0);
      sb |= q[ST_BUSY] & !q[ST_OP_IDLE];
    end
    st = q;
    chk(st[ST_DONE] | st[ST_FAIL], 1'b1);
    if (!(st[ST_DONE] | st[ST_FAIL]))
      report_and_stop;
    bus(1, REG_STATUS, 32'h6);
    q = '0;
  endtask

  task automatic op(input logic [3:0] c);
    bus(1, REG_CMD, {28'h0, c});
    q = '0;
    fin;
  endtask

  task automatic setup(input logic [31:0] a, input logic [31:0] d);
    bus(1, REG_ADDR, a);
    bus(1, REG_WDATA, d);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    bus(0, REG_STATUS, 32'h0);
    chk(q, 32'h20);
    setup(32'hffffffff, 32'hffffffff);
    bus(0, REG_ADDR, 32'h0);
    chk(q, 32'h000fffff);
    bus(0, REG_WDATA, 32'h0);
    chk(q, 32'h0000ffff);
    bus(1, 5'h1c, 32'h1);
    bus(0, 5'h1c, 32'h0);
    chk(q, 32'h0);
    $display("regs test done");
  endtask

  task automatic t_prog;
    setup(32'h12345, 32'h5aa5);
    op(4'h2);
    chk(st[2:0], 3'b010);
    chk(sb, 1'b1);
    bus(0, REG_RDATA, 32'h0);
    chk(q, 32'h5aa5);
    chk(FLASH.mem[8'h45], 16'h5aa5);
    bus(0, REG_STATUS, 32'h0);
    chk(q, 32'h20);
    $display("program test done");
  endtask

  task automatic t_stall;
    setup(32'h12346, 32'h0033);
    bus(1, REG_CMD, 32'h2);
    bus(1, REG_CMD, 32'h0);
    chk(waits > 8, 1'b1);
    bus(1, REG_STATUS, 32'h6);
    q = '0;
    fin;
    bus(0, REG_RDATA, 32'h0);
    chk(q, 32'h0033);
    $display("stall test done");
  endtask

  task automatic t_byp;
    op(4'h4);
    chk(st[ST_BYPASS], 1'b1);
    setup(32'h0, 32'h1234);
    op(4'h2);
    chk(FLASH.mem[8'h00], 16'h1234);
    op(4'h5);
    chk({st[ST_BYPASS], FLASH.byp}, 2'b00);
    $display("bypass test done");
  endtask

  task automatic t_id;
    op(4'h6);
    bus(0, REG_RDATA, 32'h0);
    chk(q, 32'h1357);
    chk(FLASH.ident, 1'b0);
    $display("ident test done");
  endtask

  task automatic t_erase;
    setup(32'h12345, 32'h0);
    op(4'h3);
    chk({st[2:0], sb}, 4'b0101);
    op(4'h0);
    bus(0, REG_RDATA, 32'h0);
    chk(q, 32'hffff);
    $display("erase test done");
  endtask

  task automatic t_misc;
    setup(32'h12345, 32'h0);
    op(4'h9);
    chk({FLASH.la, FLASH.lcmd}, {ADR_QUERY, CMD_QUERY});
    op(4'h7);
    chk({st[ST_SUSP], FLASH.la, FLASH.lcmd}, {1'b1, 11'h345, CMD_SUSP});
    op(4'h8);
    chk({st[ST_SUSP], FLASH.lcmd}, {1'b0, CMD_RESUME});
    op(4'ha);
    chk(FLASH.lcmd, CMD_UNPROT);
    op(4'h1);
    chk(FLASH.lcmd, CMD_RESET);
    op(4'hf);
    chk(FLASH.lcmd, CMD_RESET);
    $display("misc test done");
  endtask

  task automatic t_fail;
    stuck <= 1;
    setup(32'h10, 32'h1);
    op(4'h2);
    chk(st[2:0], 3'b100);
    chk(FLASH.busy, 1'b0);
    stuck <= 0;
    bus(0, REG_STATUS, 32'h0);
    chk(q, 32'h20);
    $display("fail test done");
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1;
    t_regs;
    t_prog;
    t_stall;
    t_byp;
    t_id;
    t_erase;
    t_misc;
    t_fail;
    report_and_stop;
  end
endmodule
